/* File: core/led_spi_port.sv */
`timescale 1ns/1ps
`default_nettype none

module led_spi_port
  import led_spi_pkg::*;
#(
  parameter int unsigned FRAME_BITS = FRAME_BITS_DEF
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       sclk,
  input  wire logic       chip_select_n,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe,
  input  wire logic       off_mode_exit,
  input  wire logic [7:0] led_on_voltage_first_in,
  input  wire logic [7:0] led_off_voltage_first_in,
  input  wire logic [7:0] led_on_voltage_second_in,
  input  wire logic [7:0] led_off_voltage_second_in,
  input  wire logic [7:0] die_temperature_in,
  input  wire logic [7:0] nonvolatile_read_low_in,
  input  wire logic [7:0] nonvolatile_read_high_in,
  input  wire logic [7:0] bootstrap_undervoltage_in,
  input  wire logic [7:0] current_voltage_flags_in,
  input  wire logic [1:0] pwm_state_in,
  input  wire logic       nonvolatile_ok_set,
  input  wire logic       nonvolatile_fail_set,
  input  wire logic [7:0] primary_status_in,
  input  wire logic [7:0] input_voltage_in,
  output logic [7:0]      device_function_control,
  output logic [7:0]      gate_drive_supply,
  output logic [7:0]      led_current_first_channel,
  output logic [7:0]      led_current_second_channel,
  output logic [7:0]      reserved_internal_a,
  output logic [7:0]      current_range_select,
  output logic [7:0]      current_reached_copy_pulse,
  output logic [7:0]      hysteresis_first_channel,
  output logic [7:0]      hysteresis_second_channel,
  output logic [7:0]      reserved_internal_b,
  output logic [7:0]      fallback_mode_control,
  output logic [7:0]      input_undervoltage_threshold,
  output logic [7:0]      nonvolatile_write_low,
  output logic [7:0]      nonvolatile_write_high,
  output logic [4:0]      nonvolatile_location,
  output logic            nonvolatile_read_request,
  output logic            nonvolatile_write_request,
  output logic            serial_error_flag
);

  if (FRAME_BITS != FRAME_BITS_DEF)
  begin : g_bad_frame
    $error("frame length must be sixteen bits");
  end

  // pins are asynchronous to clk, two flops each
  logic [1:0] sclk_sync_q;
  logic [1:0] cs_sync_q;
  logic [1:0] sdi_sync_q;
  logic       sclk_prev_q;
  logic       cs_prev_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sclk_sync_q <= 2'h0;
      cs_sync_q   <= 2'h3;
      sdi_sync_q  <= 2'h0;
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end
    else
    begin
      sclk_sync_q <= {sclk_sync_q[0], sclk};
      cs_sync_q   <= {cs_sync_q[0], chip_select_n};
      sdi_sync_q  <= {sdi_sync_q[0], sdi};
      sclk_prev_q <= sclk_sync_q[1];
      cs_prev_q   <= cs_sync_q[1];
    end
  end

  logic sclk_s;
  logic cs_s;
  logic sdi_s;
  logic sclk_fall;
  logic sclk_rise;
  logic frame_start;
  logic frame_end;

  assign sclk_s      = sclk_sync_q[1];
  assign cs_s        = cs_sync_q[1];
  assign sdi_s       = sdi_sync_q[1];
  assign frame_start = cs_prev_q & ~cs_s;
  assign frame_end   = ~cs_prev_q & cs_s;
  assign sclk_fall   = ~cs_s & sclk_prev_q & ~sclk_s;
  assign sclk_rise   = ~cs_s & ~sclk_prev_q & sclk_s;

  logic [FRAME_BITS-1:0] shift_q;
  logic [CNT_W-1:0]      bit_cnt_q;
  logic                  whole_word_q;
  logic                  first_frame_q;
  logic [7:0]            resp_q;
  logic                  sdo_q;
  logic                  sdo_oe_q;

  logic       cmd_read;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_data;
  logic       count_ok;
  logic       do_write;

  assign cmd_read = shift_q[RW_BIT];
  assign cmd_addr = shift_q[ADDR_MSB:ADDR_LSB];
  assign cmd_data = shift_q[DATA_MSB:DATA_LSB];
  assign count_ok = whole_word_q && (bit_cnt_q == '0);
  assign do_write = frame_end && count_ok && !cmd_read;

  // diagnostic and control state
  logic [7:0] func_ctrl_q;
  logic [7:0] gate_sup_q;
  logic [7:0] led_cur1_q;
  logic [7:0] led_cur2_q;
  logic [7:0] int_a_q;
  logic [7:0] cur_range_q;
  logic [7:0] copy_pulse_q;
  logic [7:0] hyst1_q;
  logic [7:0] hyst2_q;
  logic [7:0] int_b_q;
  logic [7:0] fallback_q;
  logic [7:0] uv_thresh_q;
  logic [7:0] nv_cmd_q;
  logic [7:0] nv_wr_lo_q;
  logic [7:0] nv_wr_hi_q;
  logic       nv_ok_q;
  logic       nv_fail_q;
  logic       err_q;
  logic       nv_rd_req_q;
  logic       nv_wr_req_q;
  logic [7:0] primary_flags;

  assign primary_flags = (primary_status_in & PRIM_MASK) | ({7'h00, err_q} << PRIM_ERR);

  function automatic logic [7:0] read_reg(input logic [6:0] a);
    logic [7:0] v;
    v = ZERO_BYTE;
    case (a)
      A_FUNC_CTRL:  v = func_ctrl_q;
      A_GATE_SUP:   v = gate_sup_q;
      A_LED_CUR1:   v = led_cur1_q;
      A_LED_CUR2:   v = led_cur2_q;
      A_INT_A:      v = int_a_q;
      A_CUR_RANGE:  v = cur_range_q;
      A_COPY_PULSE: v = copy_pulse_q;
      A_HYST1:      v = hyst1_q;
      A_HYST2:      v = hyst2_q;
      A_INT_B:      v = int_b_q;
      A_FALLBACK:   v = fallback_q;
      A_UV_THRESH:  v = uv_thresh_q;
      A_NV_CMD:     v = nv_cmd_q;
      A_NV_WR_LO:   v = nv_wr_lo_q;
      A_NV_WR_HI:   v = nv_wr_hi_q;
      A_LED_ON1:    v = led_on_voltage_first_in;
      A_LED_OFF1:   v = led_off_voltage_first_in;
      A_LED_ON2:    v = led_on_voltage_second_in;
      A_LED_OFF2:   v = led_off_voltage_second_in;
      A_INT_C:      v = R_INT_CD;
      A_INT_D:      v = R_INT_CD;
      A_DIE_TEMP:   v = die_temperature_in;
      A_NV_RD_LO:   v = nonvolatile_read_low_in;
      A_NV_RD_HI:   v = nonvolatile_read_high_in;
      A_BOOT_UV:    v = bootstrap_undervoltage_in & PAIR_MASK;
      A_CUR_VOLT:   v = current_voltage_flags_in & CV_MASK;
      A_NV_PWM:     v = {3'h0, nv_fail_q, nv_ok_q, 1'b0, pwm_state_in};
      A_PRIMARY:    v = primary_flags;
      A_VIN_MEAS:   v = input_voltage_in;
      default:      v = ZERO_BYTE;
    endcase
    return v;
  endfunction

  function automatic logic is_addr(input logic [6:0] a, input logic [6:0] b);
    return do_write && (a == b);
  endfunction

  // control addresses backed by a register, function control aside
  function automatic logic ctrl_mapped(input logic [6:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      A_GATE_SUP, A_LED_CUR1, A_LED_CUR2, A_INT_A, A_CUR_RANGE, A_COPY_PULSE,
      A_HYST1, A_HYST2, A_INT_B, A_FALLBACK, A_UV_THRESH, A_NV_CMD, A_NV_WR_LO,
      A_NV_WR_HI: hit = 1'b1;
      default:    hit = 1'b0;
    endcase
    return hit;
  endfunction

  // bit counting per chip-select period
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      bit_cnt_q    <= '0;
      whole_word_q <= 1'b0;
    end
    else if (frame_start)
    begin
      bit_cnt_q    <= '0;
      whole_word_q <= 1'b0;
    end
    else if (sclk_fall)
    begin
      bit_cnt_q <= bit_cnt_q + 1'b1;
      if (bit_cnt_q == '1)
      begin
        whole_word_q <= 1'b1;
      end
    end
  end

  // one shifter serves both directions, so a chained frame comes out 16 bits late
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      shift_q <= '0;
    end
    else if (frame_start)
    begin
      if (first_frame_q)
      begin
        shift_q <= '0;
      end
      else
      begin
        shift_q <= {primary_flags, resp_q};
      end
    end
    else if (sclk_fall)
    begin
      shift_q <= {shift_q[FRAME_BITS-2:0], sdi_s};
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      first_frame_q <= 1'b1;
    end
    else if (off_mode_exit)
    begin
      first_frame_q <= 1'b1;
    end
    else if (frame_start)
    begin
      first_frame_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sdo_q <= 1'b0;
    end
    else if (frame_start)
    begin
      sdo_q <= first_frame_q ? 1'b0 : primary_flags[7];
    end
    else if (sclk_rise)
    begin
      sdo_q <= shift_q[FRAME_BITS-1];
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sdo_oe_q <= 1'b0;
    end
    else
    begin
      sdo_oe_q <= ~cs_s;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      resp_q <= ZERO_BYTE;
    end
    else if (frame_end && count_ok)
    begin
      if (cmd_read)
      begin
        resp_q <= read_reg(cmd_addr);
      end
      else if (cmd_addr == A_FUNC_CTRL)
      begin
        resp_q <= cmd_data & FC_MASK;
      end
      else if (cmd_addr <= LAST_CTRL[6:0])
      begin
        // decode by address; a value test would miss registers still at zero
        resp_q <= ctrl_mapped(cmd_addr) ? cmd_data : ZERO_BYTE;
      end
      else
      begin
        resp_q <= read_reg(cmd_addr);
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      func_ctrl_q  <= R_FUNC_CTRL;
      gate_sup_q   <= R_GATE_SUP;
      led_cur1_q   <= R_LED_CUR;
      led_cur2_q   <= R_LED_CUR;
      int_a_q      <= R_INT_A;
      cur_range_q  <= R_CUR_RANGE;
      copy_pulse_q <= R_COPY_PULSE;
      hyst1_q      <= R_HYST;
      hyst2_q      <= R_HYST;
      int_b_q      <= R_INT_B;
      fallback_q   <= R_FALLBACK;
      uv_thresh_q  <= R_UV_THRESH;
      nv_cmd_q     <= R_NV;
      nv_wr_lo_q   <= R_NV;
      nv_wr_hi_q   <= R_NV;
    end
    else
    begin
      // reads and bad frames store nothing
      if (is_addr(cmd_addr, A_FUNC_CTRL))  func_ctrl_q  <= cmd_data & FC_MASK;
      if (is_addr(cmd_addr, A_GATE_SUP))   gate_sup_q   <= cmd_data;
      if (is_addr(cmd_addr, A_LED_CUR1))   led_cur1_q   <= cmd_data;
      if (is_addr(cmd_addr, A_LED_CUR2))   led_cur2_q   <= cmd_data;
      if (is_addr(cmd_addr, A_INT_A))      int_a_q      <= cmd_data;
      if (is_addr(cmd_addr, A_CUR_RANGE))  cur_range_q  <= cmd_data;
      if (is_addr(cmd_addr, A_COPY_PULSE)) copy_pulse_q <= cmd_data;
      if (is_addr(cmd_addr, A_HYST1))      hyst1_q      <= cmd_data;
      if (is_addr(cmd_addr, A_HYST2))      hyst2_q      <= cmd_data;
      if (is_addr(cmd_addr, A_INT_B))      int_b_q      <= cmd_data;
      if (is_addr(cmd_addr, A_FALLBACK))   fallback_q   <= cmd_data;
      if (is_addr(cmd_addr, A_UV_THRESH))  uv_thresh_q  <= cmd_data;
      if (is_addr(cmd_addr, A_NV_CMD))     nv_cmd_q     <= cmd_data;
      if (is_addr(cmd_addr, A_NV_WR_LO))   nv_wr_lo_q   <= cmd_data;
      if (is_addr(cmd_addr, A_NV_WR_HI))   nv_wr_hi_q   <= cmd_data;
    end
  end

  // nonvolatile start strobes, one cycle each
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      nv_rd_req_q <= 1'b0;
      nv_wr_req_q <= 1'b0;
    end
    else
    begin
      nv_rd_req_q <= is_addr(cmd_addr, A_NV_CMD) && cmd_data[NV_RD_BIT];
      nv_wr_req_q <= is_addr(cmd_addr, A_NV_CMD) && cmd_data[NV_WR_BIT];
    end
  end

  // write clears flags, a new set wins
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      nv_ok_q   <= 1'b0;
      nv_fail_q <= 1'b0;
    end
    else
    begin
      if (nonvolatile_ok_set)
      begin
        nv_ok_q <= 1'b1;
      end
      else if (is_addr(cmd_addr, A_NV_PWM))
      begin
        nv_ok_q <= 1'b0;
      end
      if (nonvolatile_fail_set)
      begin
        nv_fail_q <= 1'b1;
      end
      else if (is_addr(cmd_addr, A_NV_PWM))
      begin
        nv_fail_q <= 1'b0;
      end
    end
  end

  // error sticks until cleared through function control; a new fault wins
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      err_q <= 1'b0;
    end
    else if (frame_end && !count_ok)
    begin
      err_q <= 1'b1;
    end
    else if (is_addr(cmd_addr, A_VIN_MEAS))
    begin
      err_q <= 1'b1;
    end
    else if (is_addr(cmd_addr, A_FUNC_CTRL) && cmd_data[FC_CLR_ERR])
    begin
      err_q <= 1'b0;
    end
  end

  assign sdo                          = sdo_q;
  assign sdo_oe                       = sdo_oe_q;
  assign device_function_control      = func_ctrl_q;
  assign gate_drive_supply            = gate_sup_q;
  assign led_current_first_channel    = led_cur1_q;
  assign led_current_second_channel   = led_cur2_q;
  assign reserved_internal_a          = int_a_q;
  assign current_range_select         = cur_range_q;
  assign current_reached_copy_pulse   = copy_pulse_q;
  assign hysteresis_first_channel     = hyst1_q;
  assign hysteresis_second_channel    = hyst2_q;
  assign reserved_internal_b          = int_b_q;
  assign fallback_mode_control        = fallback_q;
  assign input_undervoltage_threshold = uv_thresh_q;
  assign nonvolatile_write_low        = nv_wr_lo_q;
  assign nonvolatile_write_high       = nv_wr_hi_q;
  assign nonvolatile_location         = nv_cmd_q[NV_LOC_MSB:0];
  assign nonvolatile_read_request     = nv_rd_req_q;
  assign nonvolatile_write_request    = nv_wr_req_q;
  assign serial_error_flag            = err_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_sdo_float: assert property (sdo_oe_q |-> !$past(cs_s))
    else $error("output driven while deselected");
  a_shift_sample: assert property (sclk_fall |=> shift_q[0] == $past(sdi_s))
    else $error("input bit not sampled on falling edge");
  a_status_top: assert property (frame_start && !first_frame_q
                                 |=> shift_q[15:8] == $past(primary_flags))
    else $error("status byte not loaded");
  a_first_zero: assert property (frame_start && first_frame_q |=> shift_q == '0)
    else $error("first frame not zero");
  a_read_resp: assert property (frame_end && count_ok && cmd_read
                                |=> resp_q == $past(read_reg(cmd_addr)))
    else $error("read answer wrong");
  a_read_keeps: assert property (frame_end && cmd_read |=> $stable(led_cur1_q))
    else $error("read frame changed register");
  a_bad_count: assert property (frame_end && !count_ok
                                |=> err_q && $stable(gate_sup_q))
    else $error("bad bit count not handled");
  a_vin_write: assert property (do_write && cmd_addr == A_VIN_MEAS |=> err_q)
    else $error("input voltage write not flagged");
  a_nv_clear: assert property (do_write && cmd_addr == A_NV_PWM && !nonvolatile_ok_set
                               |=> !nv_ok_q)
    else $error("nonvolatile flag not cleared");
  a_chain_delay: assert property (sclk_fall ##1 (!sclk_fall && !frame_start)[*1]
                                  |-> shift_q[15] == $past(shift_q[14], 2))
    else $error("chain shift broken");

endmodule // led_spi_port

`default_nettype wire

/* File: include/led_spi_pkg.sv */
`default_nettype none

package led_spi_pkg;

  localparam int unsigned FRAME_BITS_DEF = 16;
  localparam int unsigned CNT_W          = 4;

  // frame fields
  localparam int unsigned RW_BIT    = 15;
  localparam int unsigned ADDR_MSB  = 14;
  localparam int unsigned ADDR_LSB  = 8;
  localparam int unsigned DATA_MSB  = 7;
  localparam int unsigned DATA_LSB  = 0;
  localparam int unsigned LAST_CTRL = 7'h1f;

  // register offsets
  localparam logic [6:0] A_FUNC_CTRL  = 7'h00;
  localparam logic [6:0] A_GATE_SUP   = 7'h01;
  localparam logic [6:0] A_LED_CUR1   = 7'h02;
  localparam logic [6:0] A_LED_CUR2   = 7'h03;
  localparam logic [6:0] A_INT_A      = 7'h04;
  localparam logic [6:0] A_CUR_RANGE  = 7'h05;
  localparam logic [6:0] A_COPY_PULSE = 7'h06;
  localparam logic [6:0] A_HYST1      = 7'h0b;
  localparam logic [6:0] A_HYST2      = 7'h0c;
  localparam logic [6:0] A_INT_B      = 7'h0d;
  localparam logic [6:0] A_FALLBACK   = 7'h0e;
  localparam logic [6:0] A_UV_THRESH  = 7'h0f;
  localparam logic [6:0] A_NV_CMD     = 7'h17;
  localparam logic [6:0] A_NV_WR_LO   = 7'h18;
  localparam logic [6:0] A_NV_WR_HI   = 7'h19;
  localparam logic [6:0] A_LED_ON1    = 7'h20;
  localparam logic [6:0] A_LED_OFF1   = 7'h21;
  localparam logic [6:0] A_LED_ON2    = 7'h22;
  localparam logic [6:0] A_LED_OFF2   = 7'h23;
  localparam logic [6:0] A_INT_C      = 7'h24;
  localparam logic [6:0] A_INT_D      = 7'h25;
  localparam logic [6:0] A_DIE_TEMP   = 7'h26;
  localparam logic [6:0] A_NV_RD_LO   = 7'h28;
  localparam logic [6:0] A_NV_RD_HI   = 7'h29;
  localparam logic [6:0] A_BOOT_UV    = 7'h34;
  localparam logic [6:0] A_CUR_VOLT   = 7'h35;
  localparam logic [6:0] A_NV_PWM     = 7'h36;
  localparam logic [6:0] A_PRIMARY    = 7'h37;
  localparam logic [6:0] A_VIN_MEAS   = 7'h38;

  // reset values
  localparam logic [7:0] R_FUNC_CTRL  = 8'h0e;
  localparam logic [7:0] R_GATE_SUP   = 8'h96;
  localparam logic [7:0] R_LED_CUR    = 8'h00;
  localparam logic [7:0] R_INT_A      = 8'h17;
  localparam logic [7:0] R_CUR_RANGE  = 8'h07;
  localparam logic [7:0] R_COPY_PULSE = 8'h00;
  localparam logic [7:0] R_HYST       = 8'h03;
  localparam logic [7:0] R_INT_B      = 8'h03;
  localparam logic [7:0] R_FALLBACK   = 8'h00;
  localparam logic [7:0] R_UV_THRESH  = 8'hff;
  localparam logic [7:0] R_NV         = 8'h00;
  localparam logic [7:0] R_INT_CD     = 8'h00;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

  // field positions and masks
  localparam int unsigned FC_CLR_ERR  = 6;
  localparam logic [7:0]  FC_MASK     = 8'hbe;
  localparam logic [7:0]  PAIR_MASK   = 8'h03;
  localparam logic [7:0]  CV_MASK     = 8'h1b;
  localparam logic [7:0]  PRIM_MASK   = 8'hbb;
  localparam int unsigned PRIM_ERR    = 6;
  localparam int unsigned NV_RD_BIT   = 7;
  localparam int unsigned NV_WR_BIT   = 6;
  localparam int unsigned NV_LOC_MSB  = 4;
  localparam int unsigned NV_FAIL_BIT = 4;
  localparam int unsigned NV_OK_BIT   = 3;

endpackage

`default_nettype wire

/* File: bench/spi_master_model.sv */
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
  output logic      sclk,
  output logic      chip_select_n,
  output logic      sdi,
  input  wire logic miso
);

  initial
  begin
    sclk          = 1'b0;
    chip_select_n = 1'b1;
    sdi           = 1'b0;
  end

  // frame held under chip select, msb first
  task automatic xfer(input int n, input logic [47:0] tx, output logic [47:0] rx);
    rx            = '0;
    chip_select_n = 1'b0;
    #53;
    for (int i = n - 1; i >= 0; i--)
    begin
      // drive on rise, sample on fall
      sclk = 1'b1;
      sdi  = tx[i];
      #40;
      sclk  = 1'b0;
      rx[i] = miso;
      #40;
    end
    // clock rests low; released data toggles so it never looks held
    sdi = ~sdi;
    #10;
    chip_select_n = 1'b1;
    #80;
  endtask

endmodule // spi_master_model

`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  import led_spi_pkg::*;

  logic        clk           = 1'b0;
  logic        reset         = 1'b1;
  logic        off_mode_exit = 1'b0;
  logic        ok_set        = 1'b0;
  logic        fail_set      = 1'b0;
  logic [7:0]  live          = 8'hd6;
  logic        err           = 1'b0;
  logic [7:0]  prev          = 8'h00;
  logic [7:0]  gate, cur2;
  logic [4:0]  loc;
  logic        rd_req, sdo, sdo_oe, sclk, chip_select_n, sdi;
  logic        wr_req, err_o;
  logic        first         = 1'b1;
  logic [47:0] rx;
  logic [14:0] tbl [31];
  int          rq_n = 0;
  int          wq_n = 0;
  int          num_errors = 0;
  int          samples_checked = 0;
  wire logic   miso = sdo_oe ? sdo : 1'bz;

  always #5 clk = ~clk;

  spi_master_model m (.sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi), .miso(miso));

  led_spi_port dut (
    .clk                          (clk),
    .reset                        (reset),
    .sclk                         (sclk),
    .chip_select_n                (chip_select_n),
    .sdi                          (sdi),
    .sdo                          (sdo),
    .sdo_oe                       (sdo_oe),
    .off_mode_exit                (off_mode_exit),
    .led_on_voltage_first_in      (live),
    .led_off_voltage_first_in     (~live),
    .led_on_voltage_second_in     (live ^ 8'h0f),
    .led_off_voltage_second_in    (live ^ 8'hf0),
    .die_temperature_in           ({live[3:0], live[7:4]}),
    .nonvolatile_read_low_in      (live + 8'h01),
    .nonvolatile_read_high_in     (live + 8'h02),
    .bootstrap_undervoltage_in    (live),
    .current_voltage_flags_in     (live),
    .pwm_state_in                 (live[1:0]),
    .nonvolatile_ok_set           (ok_set),
    .nonvolatile_fail_set         (fail_set),
    .primary_status_in            (live),
    .input_voltage_in             (live - 8'h01),
    .device_function_control      (),
    .gate_drive_supply            (gate),
    .led_current_first_channel    (),
    .led_current_second_channel   (cur2),
    .reserved_internal_a          (),
    .current_range_select         (),
    .current_reached_copy_pulse   (),
    .hysteresis_first_channel     (),
    .hysteresis_second_channel    (),
    .reserved_internal_b          (),
    .fallback_mode_control        (),
    .input_undervoltage_threshold (),
    .nonvolatile_write_low        (),
    .nonvolatile_write_high       (),
    .nonvolatile_location         (loc),
    .nonvolatile_read_request     (rd_req),
    .nonvolatile_write_request    (wr_req),
    .serial_error_flag            (err_o)
  );

  always @(posedge clk)
  begin
    if (rd_req === 1'b1)
      rq_n <= rq_n + 1;
    if (wr_req === 1'b1)
      wq_n <= wq_n + 1;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] stat();
    return (live & PRIM_MASK) | {1'b0, err, 6'h00};
  endfunction

  // one 16-bit frame; nxt is the answer it should earn in the next frame
  task automatic cmd(input logic rw, input logic [6:0] a, input logic [7:0] d,
                     input logic [7:0] nxt);
    chk({15'h0, sdo_oe}, 16'h0);
    m.xfer(16, {32'h0, rw, a, d}, rx);
    chk(rx[15:0], first ? 16'h0000 : {stat(), prev});
    first = 1'b0;
    prev = nxt;
  endtask

  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  initial
  begin
    tbl = '{{7'h00, 8'h0e}, {7'h01, 8'h96}, {7'h02, 8'h00}, {7'h03, 8'h00},
            {7'h04, 8'h17}, {7'h05, 8'h07}, {7'h06, 8'h00}, {7'h0b, 8'h03},
            {7'h0c, 8'h03}, {7'h0d, 8'h03}, {7'h0e, 8'h00}, {7'h0f, 8'hff},
            {7'h17, 8'h00}, {7'h18, 8'h00}, {7'h19, 8'h00}, {7'h20, live},
            {7'h21, ~live}, {7'h22, live ^ 8'h0f}, {7'h23, live ^ 8'hf0},
            {7'h24, 8'h00}, {7'h25, 8'h00}, {7'h26, {live[3:0], live[7:4]}},
            {7'h28, live + 8'h01}, {7'h29, live + 8'h02}, {7'h34, live & 8'h03},
            {7'h35, live & 8'h1b}, {7'h36, {6'h00, live[1:0]}}, {7'h37, stat()},
            {7'h38, live - 8'h01}, {7'h50, 8'h00}, {7'h7f, 8'h00}};
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (5) @(posedge clk);
    #3;
    // reads carry a data byte of ff that must be ignored
    foreach (tbl[i])
      cmd(1'b1, tbl[i][14:8], 8'hff, tbl[i][7:0]);
    cmd(1'b1, 7'h02, 8'hff, 8'h00);
    cmd(0, 7'h01, 8'h5a, 8'h5a);
    chk({8'h0, gate}, 16'h005a);
    cmd(0, 7'h00, 8'hff, 8'hbe);
    m.xfer(17, 48'h266, rx);
    chk({15'h0, err_o}, 16'h0001);
    err = 1'b1;
    // the 17-bit frame tried to write 66 to the first channel current
    cmd(1'b1, 7'h02, 8'h00, 8'h00);
    cmd(0, 7'h00, 8'h4e, 8'h0e);
    chk({15'h0, err_o}, 16'h0000);
    err = 1'b0;
    cmd(0, 7'h38, 8'h12, live - 8'h01);
    chk({15'h0, err_o}, 16'h0001);
    err = 1'b1;
    cmd(0, 7'h00, 8'h4e, 8'h0e);
    err = 1'b0;
    chk({15'h0, sdo_oe}, 16'h0);
    m.xfer(32, {16'h0, 16'ha5c3, 1'b0, 7'h03, 8'h11}, rx);
    chk(rx[31:16], {stat(), prev});
    chk(rx[15:0], 16'ha5c3);
    prev = 8'h11;
    chk({8'h0, cur2}, 16'h0011);
    // internal registers are left untouched by this master
    cmd(0, 7'h17, 8'h85, 8'h85);
    chk({11'h0, loc}, 16'h0005);
    chk(16'(rq_n), 16'h0001);
    cmd(1'b0, 7'h17, 8'h43, 8'h43);
    chk({11'h0, loc}, 16'h0003);
    chk(16'(wq_n), 16'h0001);
    chk(16'(rq_n), 16'h0001);
    @(posedge clk);
    ok_set   <= 1'b1;
    fail_set <= 1'b1;
    @(posedge clk);
    ok_set   <= 1'b0;
    fail_set <= 1'b0;
    #3;
    cmd(1'b1, 7'h36, 8'h00, {3'h0, 1'b1, 1'b1, 1'b0, live[1:0]});
    m.xfer(16, {32'h0, 16'h3600}, rx);
    chk(rx[15:0], {stat(), prev});
    m.xfer(16, {32'h0, 16'hb600}, rx);
    prev = {6'h00, live[1:0]};
    cmd(1'b1, 7'h05, 8'h00, 8'h07);
    @(posedge clk);
    off_mode_exit <= 1'b1;
    @(posedge clk);
    off_mode_exit <= 1'b0;
    #3;
    m.xfer(16, {32'h0, 16'h8500}, rx);
    chk(rx[15:0], 16'h0000);
    prev = 8'h07;
    cmd(1'b1, 7'h00, 8'h00, 8'h00);
    wrap_up();
  end

endmodule // tb

`default_nettype wire
